// ---- tps_scan_seq.sv ----
// Panel scan sequencer: tick, three-slot frame, display multiplex, analog
// refresh, key scan, infrared capture and time-of-day keeping.
// Assumes key rows and the infrared pulse come from pins (synchronised here)
// and that the buffer write ports come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module tps_scan_seq #(
  parameter int unsigned TICK_CYCLES = tps_pkg::TICK_CYCLES_DEF,
  parameter int unsigned IR_DIV      = tps_pkg::IR_DIV_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        digit_wr,
  input  wire logic [2:0]  digit_idx,
  input  wire logic [3:0]  digit_val,
  input  wire logic        ana_wr,
  input  wire logic [1:0]  ana_idx,
  input  wire logic [5:0]  ana_val,
  input  wire logic [1:0]  key_row_pin,
  input  wire logic        ir_pulse_pin,
  output logic [15:0]      out_word,
  output logic             out_load,
  output logic             tick,
  output logic [1:0]       slot,
  output logic [4:0]       key_code,
  output logic             key_valid,
  output logic [6:0]       remote_char,
  output logic             remote_valid,
  output logic             sec_pulse
);
  localparam int unsigned IR_DIV_W_L = tps_pkg::IR_DIV_W;

  tps_pkg::tps_state_e     state_reg;
  logic [tps_pkg::TICK_CNT_W-1:0] tick_cnt_reg;
  logic                    tick_reg;
  logic [1:0]              slot_reg;
  logic [1:0]              ptr_reg;
  logic [1:0]              prev_ptr_reg;
  logic [1:0]              step_reg;
  logic [2:0]              line_reg;
  logic [3:0]              disp_buf [6];
  logic [5:0]              ana_buf [4];
  logic [7:0]              tick_sec_reg;
  logic                    sec_due_reg;
  logic [5:0]              secs_reg;
  logic [15:0]             word_reg;
  logic                    load_reg;
  logic [1:0]              row_meta_reg;
  logic [1:0]              row_sync_reg;
  logic                    ir_meta_reg;
  logic                    ir_sync_reg;
  logic                    ir_last_reg;
  logic [IR_DIV_W_L-1:0]   ir_div_reg;
  logic [3:0]              ir_cnt_reg;
  logic [2:0]              ir_bits_reg;
  logic [6:0]              ir_shift_reg;
  logic                    char_ready_reg;
  logic [6:0]              char_reg;
  logic                    rem_valid_reg;
  logic [4:0]              key_code_reg;
  logic                    key_valid_reg;
  logic                    key_hit_reg;
  logic                    ir_edge;
  logic                    rem_take;
  logic                    min_roll;

  // The tick divider is the time base of the frame schedule; infrared capture keeps its own divider.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (clk_en) begin
      tick_reg <= 1'b0;
      if (tick_cnt_reg == tps_pkg::TICK_CNT_W'(TICK_CYCLES - 1)) begin
        tick_cnt_reg <= '0;
        tick_reg     <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
    end
  end

  // Slot and buffer pointer advance on each tick; three slots make the frame.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      slot_reg     <= 2'h0;
      ptr_reg      <= 2'h0;
      prev_ptr_reg <= 2'h0;
    end else if (clk_en && tick_reg) begin
      slot_reg     <= (slot_reg == tps_pkg::SLOT_LAST) ? 2'h0 : slot_reg + 1'b1;
      prev_ptr_reg <= ptr_reg;
      if (slot_reg == 2'h0) begin
        ptr_reg <= 2'h0;
      end else begin
        ptr_reg <= ptr_reg + 1'b1;
      end
    end
  end

  // One step per cycle after the tick; the whole walk is far shorter than a slot.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= tps_pkg::TPS_IDLE;
      step_reg  <= 2'h0;
      line_reg  <= 3'h0;
    end else if (clk_en) begin
      unique case (state_reg)
        tps_pkg::TPS_IDLE: begin
          if (tick_reg) begin
            state_reg <= tps_pkg::TPS_DESEL;
          end
        end
        tps_pkg::TPS_DESEL: begin
          state_reg <= tps_pkg::TPS_SEGOUT;
        end
        tps_pkg::TPS_SEGOUT: begin
          step_reg <= 2'h0;
          line_reg <= 3'h0;
          if (slot_reg == tps_pkg::SLOT_ANA) begin
            state_reg <= tps_pkg::TPS_ANA_DRV;
          end else if (slot_reg == tps_pkg::SLOT_KEY) begin
            state_reg <= tps_pkg::TPS_KEY_DRV;
          end else begin
            state_reg <= tps_pkg::TPS_REM_CHK;
          end
        end
        tps_pkg::TPS_ANA_DRV: begin
          state_reg <= tps_pkg::TPS_ANA_STB;
        end
        tps_pkg::TPS_ANA_STB: begin
          state_reg <= tps_pkg::TPS_ANA_REL;
        end
        tps_pkg::TPS_ANA_REL: begin
          if (step_reg == tps_pkg::ANA_CH_LAST) begin
            state_reg <= tps_pkg::TPS_CLK_UPD;
          end else begin
            step_reg  <= step_reg + 1'b1;
            state_reg <= tps_pkg::TPS_ANA_DRV;
          end
        end
        tps_pkg::TPS_KEY_DRV: begin
          // Pins pass two synchroniser stages, so the row is read a few cycles late.
          step_reg <= step_reg + 1'b1;
          if (step_reg == tps_pkg::KEY_SETTLE_LAST) begin
            state_reg <= tps_pkg::TPS_KEY_SMP;
          end
        end
        tps_pkg::TPS_KEY_SMP: begin
          step_reg <= 2'h0;
          if (line_reg == tps_pkg::SCAN_LINE_LAST) begin
            state_reg <= tps_pkg::TPS_CLK_UPD;
          end else begin
            line_reg  <= line_reg + 1'b1;
            state_reg <= tps_pkg::TPS_KEY_DRV;
          end
        end
        tps_pkg::TPS_REM_CHK: begin
          state_reg <= tps_pkg::TPS_CLK_UPD;
        end
        tps_pkg::TPS_CLK_UPD: begin
          state_reg <= tps_pkg::TPS_IDLE;
        end
        default: begin
          state_reg <= tps_pkg::TPS_IDLE;
        end
      endcase
    end
  end

  // Each load rewrites only the fields of its own step; the rest of the output word keeps its last value.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      word_reg <= tps_pkg::WORD_RST;
      load_reg <= 1'b0;
    end else if (clk_en) begin
      load_reg <= 1'b0;
      unique case (state_reg)
        tps_pkg::TPS_DESEL: begin
          word_reg[tps_pkg::SEL_DATA_BIT] <= 1'b0;
          word_reg[tps_pkg::SEL_ADDR_LSB +: 3] <= {1'b0, prev_ptr_reg};
          load_reg <= 1'b1;
        end
        tps_pkg::TPS_SEGOUT: begin
          word_reg[tps_pkg::SEG1_LSB +: 4] <= disp_buf[{ptr_reg, 1'b0}];
          word_reg[tps_pkg::SEG2_LSB +: 4] <= disp_buf[{ptr_reg, 1'b1}];
          word_reg[tps_pkg::SEL_DATA_BIT] <= 1'b1;
          word_reg[tps_pkg::SEL_ADDR_LSB +: 3] <= {1'b0, ptr_reg};
          load_reg <= 1'b1;
        end
        tps_pkg::TPS_ANA_DRV: begin
          word_reg[tps_pkg::ANA_LSB +: 6] <= ana_buf[step_reg];
          word_reg[tps_pkg::SEL_DATA_BIT] <= 1'b0;
          word_reg[tps_pkg::SEL_ADDR_LSB +: 3] <= tps_pkg::ANA_ADDR_BASE | {1'b0, step_reg};
          load_reg <= 1'b1;
        end
        tps_pkg::TPS_ANA_STB: begin
          word_reg[tps_pkg::SEL_DATA_BIT] <= 1'b1;
          load_reg <= 1'b1;
        end
        tps_pkg::TPS_ANA_REL: begin
          word_reg[tps_pkg::SEL_DATA_BIT] <= 1'b0;
          load_reg <= 1'b1;
        end
        tps_pkg::TPS_KEY_DRV: begin
          if (step_reg == 2'h0) begin
            word_reg[tps_pkg::SCAN_DATA_BIT] <= 1'b1;
            word_reg[tps_pkg::SCAN_ADDR_LSB +: 3] <= line_reg;
            load_reg <= 1'b1;
          end
        end
        default: begin
          word_reg <= word_reg;
        end
      endcase
    end
  end

  // Both pin inputs pass two flip-flops; rows read the second stage, the infrared edge compares the second with a third.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      row_meta_reg <= 2'h0;
      row_sync_reg <= 2'h0;
      ir_meta_reg  <= 1'b0;
      ir_sync_reg  <= 1'b0;
      ir_last_reg  <= 1'b0;
    end else if (clk_en) begin
      row_meta_reg <= key_row_pin;
      row_sync_reg <= row_meta_reg;
      ir_meta_reg  <= ir_pulse_pin;
      ir_sync_reg  <= ir_meta_reg;
      ir_last_reg  <= ir_sync_reg;
    end
  end

  assign ir_edge  = ir_sync_reg && !ir_last_reg;
  assign rem_take = (state_reg == tps_pkg::TPS_REM_CHK) && char_ready_reg;

  // Key sampling: first closure in a scan wins, shift line adds the second bank.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      key_code_reg  <= 5'h00;
      key_valid_reg <= 1'b0;
      key_hit_reg   <= 1'b0;
    end else if (clk_en) begin
      key_valid_reg <= 1'b0;
      if (state_reg == tps_pkg::TPS_SEGOUT) begin
        key_hit_reg <= 1'b0;
      end else if (state_reg == tps_pkg::TPS_KEY_SMP) begin
        if (line_reg == tps_pkg::SCAN_LINE_LAST) begin
          if (key_hit_reg) begin
            key_valid_reg <= 1'b1;
            // Row 0 seen on the last line is the shift key, read in the same pass.
            key_code_reg  <= row_sync_reg[0] ? key_code_reg + tps_pkg::KEY_SHIFT_OFS
                                                            : key_code_reg;
          end
        end else if (!key_hit_reg && (row_sync_reg != 2'h0)) begin
          key_hit_reg  <= 1'b1;
          key_code_reg <= row_sync_reg[0] ? {2'b00, line_reg}
                                          : {1'b0, 4'({1'b0, line_reg}) + tps_pkg::KEY_ROW1_OFS};
        end
      end
    end
  end

  // Infrared interval capture runs on its own pulses, never waiting for a tick.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ir_div_reg     <= '0;
      ir_cnt_reg     <= 4'h0;
      ir_bits_reg    <= 3'h0;
      ir_shift_reg   <= 7'h00;
      char_ready_reg <= 1'b0;
    end else if (clk_en) begin
      if (ir_edge) begin
        ir_div_reg   <= '0;
        ir_cnt_reg   <= 4'h0;
        ir_shift_reg <= {ir_shift_reg[5:0], ir_cnt_reg[3]};
        ir_bits_reg  <= (ir_bits_reg == tps_pkg::IR_BITS_LAST) ? 3'h0 : ir_bits_reg + 1'b1;
      end else if (ir_div_reg == IR_DIV_W_L'(IR_DIV - 1)) begin
        ir_div_reg <= '0;
        if (ir_cnt_reg != 4'hF) begin
          ir_cnt_reg <= ir_cnt_reg + 1'b1;
        end else begin
          ir_bits_reg <= 3'h0; // A long gap abandons a partial character.
        end
      end else begin
        ir_div_reg <= ir_div_reg + 1'b1;
      end
      // A completed character beats the clear in the same cycle.
      if (ir_edge && (ir_bits_reg == tps_pkg::IR_BITS_LAST)) begin
        char_ready_reg <= 1'b1;
      end else if (rem_take) begin
        char_ready_reg <= 1'b0;
      end
    end
  end

  // Remote characters are handed on only in their own slot.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      char_reg      <= 7'h00;
      rem_valid_reg <= 1'b0;
    end else if (clk_en) begin
      rem_valid_reg <= rem_take;
      if (rem_take) begin
        char_reg <= ir_shift_reg;
      end
    end
  end

  // Seconds accumulate on every tick; the rollover is applied in the update step.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_sec_reg <= 8'h00;
      sec_due_reg  <= 1'b0;
      secs_reg     <= 6'h00;
    end else if (clk_en) begin
      if (tick_reg) begin
        tick_sec_reg <= (tick_sec_reg == tps_pkg::SEC_LAST) ? 8'h00 : tick_sec_reg + 1'b1;
      end
      if (tick_reg && (tick_sec_reg == tps_pkg::SEC_LAST)) begin
        sec_due_reg <= 1'b1;
      end else if (state_reg == tps_pkg::TPS_CLK_UPD) begin
        sec_due_reg <= 1'b0;
      end
      if ((state_reg == tps_pkg::TPS_CLK_UPD) && sec_due_reg) begin
        secs_reg <= (secs_reg == tps_pkg::SEC_WRAP) ? 6'h00 : secs_reg + 1'b1;
      end
    end
  end

  assign min_roll = (state_reg == tps_pkg::TPS_CLK_UPD) && sec_due_reg && (secs_reg == tps_pkg::SEC_WRAP);

  // Display buffer: digits 0..3 hold HH MM and roll with the clock; a write from
  // the user port loses to a same-cycle rollover, which only touches clock digits.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 6; i++) begin
        disp_buf[i] <= 4'h0;
      end
    end else if (clk_en) begin
      if (digit_wr && (digit_idx < 3'h6)) begin
        disp_buf[digit_idx] <= digit_val;
      end
      if (min_roll) begin
        disp_buf[3] <= (disp_buf[3] == tps_pkg::BCD_NINE) ? 4'h0 : disp_buf[3] + 1'b1;
        if (disp_buf[3] == tps_pkg::BCD_NINE) begin
          disp_buf[2] <= (disp_buf[2] == 4'h5) ? 4'h0 : disp_buf[2] + 1'b1;
          if (disp_buf[2] == 4'h5) begin
            if ({disp_buf[0], disp_buf[1]} == 8'h23) begin
              disp_buf[0] <= 4'h0;
              disp_buf[1] <= 4'h0;
            end else if (disp_buf[1] == tps_pkg::BCD_NINE) begin
              disp_buf[0] <= disp_buf[0] + 1'b1;
              disp_buf[1] <= 4'h0;
            end else begin
              disp_buf[1] <= disp_buf[1] + 1'b1;
            end
          end
        end
      end
    end
  end

  // Stored analog levels, one per channel.
  generate
    for (genvar ch = 0; ch < 4; ch++) begin : g_ana
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          ana_buf[ch] <= 6'h00;
        end else if (clk_en && ana_wr && (ana_idx == 2'(ch))) begin
          ana_buf[ch] <= ana_val;
        end
      end
    end
  endgenerate

  assign out_word     = word_reg;
  assign out_load     = load_reg;
  assign tick         = tick_reg;
  assign slot         = slot_reg;
  assign key_code     = key_code_reg;
  assign key_valid    = key_valid_reg;
  assign remote_char  = char_reg;
  assign remote_valid = rem_valid_reg;
  assign sec_pulse    = min_roll;

  // Checks sample only enabled edges, so a frozen clock enable never trips them.
  default clocking cb @(posedge ref_clk iff clk_en); endclocking
  default disable iff (!nrst);

  chk_tick_period: assert property (tick_reg |-> $past(tick_cnt_reg) == tps_pkg::TICK_CNT_W'(TICK_CYCLES - 1))
    else $error("tick without full period");
  chk_slot_wrap: assert property (tick_reg |=> slot_reg == (($past(slot_reg) == 2'h2) ? 2'h0 : $past(slot_reg) + 2'h1))
    else $error("slot did not step");
  chk_desel_first: assert property (tick_reg && state_reg == tps_pkg::TPS_IDLE |=> ##1 load_reg && !word_reg[3] ##1 load_reg && word_reg[3])
    else $error("deselect then select order broken");
  chk_pair_select: assert property (state_reg == tps_pkg::TPS_SEGOUT |=> word_reg[2:0] == {1'b0, ptr_reg} && word_reg[15:12] == disp_buf[{ptr_reg, 1'b0}])
    else $error("wrong pair or segments");
  chk_analog_burst: assert property (state_reg == tps_pkg::TPS_SEGOUT && slot_reg == tps_pkg::SLOT_ANA |=> ##12 state_reg == tps_pkg::TPS_CLK_UPD)
    else $error("analog burst not four channels");
  chk_value_before: assert property (state_reg == tps_pkg::TPS_ANA_STB |=> word_reg[3] && $past(word_reg[3]) == 1'b0 && word_reg[13:8] == ana_buf[step_reg])
    else $error("strobe before value");
  chk_ptr_restart: assert property (tick_reg && slot_reg == 2'h0 |=> ptr_reg == 2'h0)
    else $error("pointer did not restart");
  chk_sec_count: assert property (tick_reg |=> tick_sec_reg != $past(tick_sec_reg))
    else $error("seconds counter idle on tick");
  chk_key_slot: assert property (key_valid_reg |-> slot_reg == tps_pkg::SLOT_KEY)
    else $error("key reported outside its slot");
  chk_remote_slot: assert property (rem_valid_reg |-> slot_reg == tps_pkg::SLOT_REM && $past(char_ready_reg))
    else $error("remote character passed wrongly");

  cov_analog: cover property (state_reg == tps_pkg::TPS_ANA_REL && step_reg == 2'h3);
  cov_key: cover property (key_valid_reg);
  cov_remote: cover property (rem_valid_reg);
  cov_minute: cover property (min_roll);
endmodule
`default_nettype wire

// ---- tps_pkg.sv ----
// Constants for the panel scan sequencer: timing, slot plan, word layout.
// Assumes a single 100 MHz clock; no bus reaches these values at run time.
package tps_pkg;
  // Clock rate and service tick.
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_TIME_NS    = 4_000_000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W      = 20;
  // Seconds accumulation: 1 s is 1000 ms of 4 ms ticks.
  localparam int unsigned TICK_TIME_MS    = 4;
  localparam int unsigned TICKS_PER_SEC   = 1000 / TICK_TIME_MS;
  localparam logic [7:0]  SEC_LAST        = 8'(TICKS_PER_SEC - 1);
  localparam logic [5:0]  SEC_WRAP        = 6'h3B;
  // Infrared interval time base, 10 kHz.
  localparam int unsigned IR_BASE_HZ      = 10_000;
  localparam int unsigned IR_DIV_DEF      = CLK_HZ / IR_BASE_HZ;
  localparam int unsigned IR_DIV_W        = 14;
  localparam logic [2:0]  IR_BITS_LAST    = 3'h6;
  // Slot plan of one three-slot frame.
  localparam logic [1:0]  SLOT_LAST       = 2'h2;
  localparam logic [1:0]  SLOT_REM        = 2'h0;
  localparam logic [1:0]  SLOT_ANA        = 2'h1;
  localparam logic [1:0]  SLOT_KEY        = 2'h2;
  // Output word layout.
  localparam int unsigned SEG1_LSB        = 12;
  localparam int unsigned SEG2_LSB        = 8;
  localparam int unsigned ANA_LSB         = 8;
  localparam int unsigned SCAN_DATA_BIT   = 7;
  localparam int unsigned SCAN_ADDR_LSB   = 4;
  localparam int unsigned SEL_DATA_BIT    = 3;
  localparam int unsigned SEL_ADDR_LSB    = 0;
  // Select latch addresses: pairs at 0..2, analog channels at 4..7.
  localparam logic [2:0]  ANA_ADDR_BASE   = 3'h4;
  localparam logic [1:0]  ANA_CH_LAST     = 2'h3;
  localparam logic [2:0]  SCAN_LINE_LAST  = 3'h6;
  localparam logic [3:0]  KEY_ROW1_OFS    = 4'h7;
  localparam logic [4:0]  KEY_SHIFT_OFS   = 5'h0C;
  localparam logic [1:0]  KEY_SETTLE_LAST = 2'h3;
  // Reset values.
  localparam logic [15:0] WORD_RST        = 16'h0000;
  localparam logic [3:0]  BCD_NINE        = 4'h9;
  // Sequencer states, Gray coded from TPS_IDLE through TPS_ANA_REL.
  typedef enum logic [3:0] {
    TPS_IDLE    = 4'h0,
    TPS_DESEL   = 4'h1,
    TPS_SEGOUT  = 4'h3,
    TPS_ANA_DRV = 4'h2,
    TPS_ANA_STB = 4'h6,
    TPS_ANA_REL = 4'h7,
    TPS_KEY_DRV = 4'h5,
    TPS_KEY_SMP = 4'h4,
    TPS_REM_CHK = 4'hC,
    TPS_CLK_UPD = 4'hD
  } tps_state_e;
endpackage

// ---- tps_panel_model.sv ----
// Far side of the panel scan sequencer: key matrix with one held key and a shift key, and an infrared receiver.
// Assumes out_word and out_load come from the sequencer on ref_clk; the bench calls send_char.
`timescale 1ns/1ps
`default_nettype none
module tps_panel_model (
  input  wire logic       ref_clk,
  input  wire logic [15:0] out_word,
  input  wire logic       out_load,
  input  wire logic       key_down,
  input  wire logic [2:0] key_line,
  input  wire logic       key_row,
  input  wire logic       shift_down,
  output logic [1:0]      key_row_pin,
  output logic            ir_pulse_pin
);
  logic [2:0] scan_addr_reg = 3'h0;
  logic       scan_on_reg   = 1'b0;

  // The scan latch keeps the last scan address and data bit loaded.
  always @(posedge ref_clk) begin
    if (out_load === 1'b1) begin
      scan_addr_reg <= out_word[6:4];
      scan_on_reg   <= out_word[7];
    end
  end

  // Only the driven line reaches the rows, so an idle matrix reads all zero.
  // The shift key sits on the last scan line, row 0.
  assign key_row_pin = ((key_down && scan_on_reg && scan_addr_reg == key_line) ? (key_row ? 2'h2 : 2'h1) : 2'h0)
                     | ((shift_down && scan_on_reg && scan_addr_reg == 3'h6) ? 2'h1 : 2'h0);

  initial ir_pulse_pin = 1'b0;

  // Seven pulses; a 40-cycle interval reads one and a 20-cycle interval zero.
  // The first pulse follows a long idle gap, so the leading bit always reads one.
  task automatic send_char(input logic [6:0] code);
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      #1 ir_pulse_pin = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 ir_pulse_pin = 1'b0;
      if (i < 6) repeat (code[5 - i] ? 35 : 15) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- tps_scan_seq_test.sv ----
// Self-checking bench for the panel scan sequencer with a short tick period.
// Assumes tps_pkg and tps_panel_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tps_scan_seq_test;
  localparam int unsigned TCYC = 64;
  typedef struct {logic [1:0] slot; logic [2:0] pair; logic [2:0] prev;} tps_row_s;
  tps_row_s   rows[3] = '{'{2'h1, 3'h0, 3'h2}, '{2'h2, 3'h1, 3'h0}, '{2'h0, 3'h2, 3'h1}};
  logic [3:0] digs[6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
  logic [5:0] anas[4] = '{6'h15, 6'h2A, 6'h3F, 6'h01};
  logic ref_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, digit_wr = 1'b0, ana_wr = 1'b0;
  logic [2:0] digit_idx = 3'h0, key_line = 3'h3;
  logic [3:0] digit_val = 4'h0;
  logic [1:0] ana_idx = 2'h0, key_row_pin, slot;
  logic [5:0] ana_val = 6'h00;
  logic key_down = 1'b0, key_row = 1'b1, shift_down = 1'b0, ir_pulse_pin, out_load, tick, key_valid, remote_valid;
  logic sec_pulse;
  logic [15:0] out_word;
  logic [4:0]  key_code;
  logic [6:0]  remote_char;
  int num_errors = 0, checks_done = 0;
  time t_last = 0;

  tps_scan_seq #(.TICK_CYCLES(TCYC), .IR_DIV(4)) uut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .digit_wr(digit_wr), .digit_idx(digit_idx), .digit_val(digit_val), .ana_wr(ana_wr), .ana_idx(ana_idx),
    .ana_val(ana_val), .key_row_pin(key_row_pin), .ir_pulse_pin(ir_pulse_pin), .out_word(out_word),
    .out_load(out_load), .tick(tick), .slot(slot), .key_code(key_code), .key_valid(key_valid),
    .remote_char(remote_char), .remote_valid(remote_valid), .sec_pulse(sec_pulse));
  tps_panel_model model (.ref_clk(ref_clk), .out_word(out_word), .out_load(out_load), .key_down(key_down),
    .key_line(key_line), .key_row(key_row), .shift_down(shift_down), .key_row_pin(key_row_pin),
    .ir_pulse_pin(ir_pulse_pin));

  // Free-running 100 MHz clock.
  initial forever #5 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  // Bounded waits; a wait that runs out shows up as a failed compare.
  task automatic wait_load();
    int n;
    n = 0;
    do begin step(); n++; end while (out_load !== 1'b1 && n < 8);
    chk("load", 16'h1, 16'(out_load));
  endtask

  task automatic wait_tick();
    int n;
    n = 0;
    do begin step(); n++; end while (tick !== 1'b1 && n < 1000);
    if (t_last != 0) chk("tick period", 16'(TCYC * 10), 16'($time - t_last));
    t_last = $time;
  endtask

  task automatic close_out();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog sized well past the roughly 800 cycles the tests need.
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("Error watchdog expected finish seen hang");
    close_out();
  end

  // Main sequence: table of frame slots first, then freeze, remote and reset cases.
  initial begin
    int p;
    logic [4:0] kexp;
    logic [1:0] s0;
    repeat (16) @(posedge ref_clk);
    #1 nrst = 1'b1;
    t_last = $time;
    for (int i = 0; i < 6; i++) begin
      digit_wr = 1'b1; digit_idx = 3'(i); digit_val = digs[i]; ana_wr = i < 4; ana_idx = 2'(i); ana_val = anas[i % 4];
      step();
    end
    digit_wr = 1'b0;
    ana_wr = 1'b0;
    key_down = 1'b1;
    for (int f = 0; f < 2; f++) begin
      for (int r = 0; r < 3; r++) begin
        p = rows[r].pair;
        wait_tick();
        step();
        chk("slot", 16'(rows[r].slot), 16'(slot));
        step();
        chk("deselect", {11'h0, 1'b1, 1'b0, (f + r > 0) ? rows[r].prev : 3'h0},
            {11'h0, out_load, out_word[3:0]});
        step();
        chk("select", {3'h0, 1'b1, digs[2 * p], digs[2 * p + 1], 1'b1, rows[r].pair},
            {3'h0, out_load, out_word[15:8], out_word[3:0]});
        if (rows[r].slot == tps_pkg::SLOT_ANA) begin
          for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 3; j++) begin
              wait_load();
              chk("analog", {6'h0, anas[k], j == 1, 3'(4 + k)},
                  {6'h0, out_word[13:8], out_word[3:0]});
            end
          end
        end
        if (rows[r].slot == tps_pkg::SLOT_KEY) begin
          kexp = (key_row ? 5'(key_line + 7) : 5'(key_line)) + (shift_down ? 5'h0C : 5'h00);
          for (int l = 0; l < 7; l++) begin
            wait_load();
            chk("scan", {12'h0, 1'b1, 3'(l)}, {12'h0, out_word[7:4]});
          end
          for (int n = 0; n < 10 && key_valid !== 1'b1; n++) step();
          chk("key code", {10'h0, 1'b1, kexp}, {10'h0, key_valid, key_code});
          key_line = 3'h5;
          key_row = 1'b0;
          shift_down = 1'b1;
        end
      end
      $display("Test frame %0d done", f);
    end
    // Clock enable low must freeze the tick and slot.
    s0 = slot;
    clk_en = 1'b0;
    repeat (150) begin step(); chk("frozen tick", 16'h0, 16'(tick)); end
    chk("frozen slot", 16'(s0), 16'(slot));
    clk_en = 1'b1;
    t_last = 0;
    $display("Test freeze done");
    // A remote character arrives while ticks keep running.
    fork
      model.send_char(7'h5A);
      begin
        for (int n = 0; n < 1500 && remote_valid !== 1'b1; n++) step();
        // The valid pulse lasts one cycle, so it is compared where the wait stopped.
        chk("remote char", 16'h805A, {remote_valid, 8'h0, remote_char});
      end
    join
    $display("Test remote done");
    // Second reset in mid-run clears outputs and restarts the tick count.
    step();
    nrst = 1'b0;
    step();
    chk("reset word", 16'h0, out_word);
    chk("reset flags", 16'h0, {4'h0, slot, tick, out_load, key_code, key_valid, remote_valid, sec_pulse});
    nrst = 1'b1;
    t_last = $time;
    wait_tick();
    step();
    chk("slot after reset", 16'h1, 16'(slot));
    chk("second count", 16'h1, 16'(uut.tick_sec_reg));
    $display("Test reset done");
    close_out();
  end
endmodule
`default_nettype wire
